// file: urr_pkg.sv
// Purpose: constants for the ultrasonic range readout host
// Assumes: mclk at 250 MHz
// Notes:   times in their own unit, cycle counts derived
package urr_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned TRIG_US         = 10;
  localparam int unsigned TRIG_CYC        = TRIG_US * CLK_MHZ;
  // round trip for the farthest range plus margin, in microseconds
  localparam int unsigned ECHO_TMO_US     = 38000;
  localparam int unsigned ECHO_TMO_CYC    = ECHO_TMO_US * CLK_MHZ;
  localparam int unsigned SOUND_M_PER_S   = 340;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned DIST_W          = 16;
  // distance in mm = cycles * 340 / 2 / 250000 = cycles * 17 / 25000
  localparam int unsigned DIST_NUM        = SOUND_M_PER_S / 2 / 10;
  localparam int unsigned DIST_DEN        = CLK_MHZ * 100;
  typedef enum logic [4:0] {
    URR_IDLE  = 5'h01,
    URR_TRIG  = 5'h02,
    URR_WRISE = 5'h04,
    URR_WFALL = 5'h08,
    URR_CALC  = 5'h10
  } urr_state_t;
endpackage

// file: urr_host.sv
// Purpose: host that triggers an ultrasonic ranger and times its echo
// Assumes: echo pin asynchronous to mclk; one measurement at a time
// Notes:   distance reported in millimetres
// Behaviour
// [R1] trigger low, echo treated idle low at start
// [R2] trigger high at least 10 us
// [R3] sensor bursts eight 40 kHz cycles itself
// [R4] start counting at echo rising edge
// [R5] read count at echo falling edge
// [R6] echo high time proportional to distance
// [R7] distance is time times 340 over two
// [R8] timeout abandons measurement, no result
`timescale 1ns/10ps
module urr_host #(
  parameter int unsigned TRIG_CYCLES = urr_pkg::TRIG_CYC,
  parameter int unsigned TMO_CYCLES  = urr_pkg::ECHO_TMO_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      startReq,
  output logic                           busy,
  output logic                           trigOut,
  input  wire logic                      echoIn,
  output logic                           resultValid,
  output logic                           resultTimeout,
  output logic [urr_pkg::CNT_W-1:0]      echoCycles,
  output logic [urr_pkg::DIST_W-1:0]     distanceMm
);
  urr_pkg::urr_state_t             state_reg, state_next;
  logic [urr_pkg::CNT_W-1:0]       cnt_reg, cnt_next;
  logic [urr_pkg::CNT_W-1:0]       cap_reg, cap_next;
  logic [urr_pkg::DIST_W-1:0]      dist_reg, dist_next;
  logic                            trig_reg, trig_next;
  logic                            valid_reg, valid_next;
  logic                            tmo_reg, tmo_next;
  logic                            echoMeta_reg, echoSync_reg, echoPrev_reg;
  logic                            echoRise, echoFall;
  logic [urr_pkg::CNT_W+7:0]       product;
  logic [urr_pkg::CNT_W-1:0]       trigLen_reg, trigLen_next;

  // two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      echoMeta_reg <= 1'b0;
      echoSync_reg <= 1'b0;
      echoPrev_reg <= 1'b0;
    end else begin
      echoMeta_reg <= echoIn;
      echoSync_reg <= echoMeta_reg;
      echoPrev_reg <= echoSync_reg;
    end
  end
  assign echoRise = echoSync_reg & ~echoPrev_reg;
  assign echoFall = ~echoSync_reg & echoPrev_reg;

  assign product = (urr_pkg::CNT_W+8)'(cap_reg) * (urr_pkg::CNT_W+8)'(urr_pkg::DIST_NUM);

  // counter has reached the last cycle of a window of len cycles
  function automatic logic atLimit(input logic [urr_pkg::CNT_W-1:0] cnt,
                                   input int unsigned                len);
    return cnt >= urr_pkg::CNT_W'(len - 1);
  endfunction

  // assertion helper: cycles the trigger has stood high so far
  always_comb begin
    trigLen_next = '0;
    if (trig_reg) begin
      trigLen_next = trigLen_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trigLen_reg <= '0;
    end else begin
      trigLen_reg <= trigLen_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cap_next   = cap_reg;
    dist_next  = dist_reg;
    trig_next  = 1'b0;                                  // [R1]
    valid_next = 1'b0;
    tmo_next   = 1'b0;
    case (state_reg)
      urr_pkg::URR_IDLE: begin
        cnt_next = '0;
        // wait for echo idle low before starting
        if (startReq && !echoSync_reg) begin            // [R1]
          state_next = urr_pkg::URR_TRIG;
          trig_next  = 1'b1;
        end
      end
      urr_pkg::URR_TRIG: begin
        trig_next = 1'b1;                               // [R2]
        cnt_next  = cnt_reg + 1'b1;
        if (atLimit(cnt_reg, TRIG_CYCLES)) begin
          trig_next  = 1'b0;
          cnt_next   = '0;
          state_next = urr_pkg::URR_WRISE;              // [R3]
        end
      end
      urr_pkg::URR_WRISE: begin
        cnt_next = cnt_reg + 1'b1;
        if (echoRise) begin
          cnt_next   = '0;                              // [R4]
          state_next = urr_pkg::URR_WFALL;
        end else if (atLimit(cnt_reg, TMO_CYCLES)) begin
          tmo_next   = 1'b1;                            // [R8]
          state_next = urr_pkg::URR_IDLE;
        end
      end
      urr_pkg::URR_WFALL: begin
        cnt_next = cnt_reg + 1'b1;
        if (echoFall) begin
          cap_next   = cnt_reg;                         // [R5] [R6]
          state_next = urr_pkg::URR_CALC;
        end else if (atLimit(cnt_reg, TMO_CYCLES)) begin
          tmo_next   = 1'b1;                            // [R8]
          state_next = urr_pkg::URR_IDLE;
        end
      end
      urr_pkg::URR_CALC: begin
        dist_next  = urr_pkg::DIST_W'(product / urr_pkg::DIST_DEN); // [R7]
        valid_next = 1'b1;
        state_next = urr_pkg::URR_IDLE;
      end
      default: state_next = urr_pkg::URR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= urr_pkg::URR_IDLE;
      cnt_reg   <= '0;
      cap_reg   <= '0;
      dist_reg  <= '0;
      trig_reg  <= 1'b0;
      valid_reg <= 1'b0;
      tmo_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cap_reg   <= cap_next;
      dist_reg  <= dist_next;
      trig_reg  <= trig_next;
      valid_reg <= valid_next;
      tmo_reg   <= tmo_next;
    end
  end

  assign busy          = (state_reg != urr_pkg::URR_IDLE);
  assign trigOut       = trig_reg;
  assign resultValid   = valid_reg;
  assign resultTimeout = tmo_reg;
  assign echoCycles    = cap_reg;
  assign distanceMm    = dist_reg;

  chk_trig_low_idle: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    (state_reg == urr_pkg::URR_IDLE) |-> !trigOut)
    else $error("trigger high while idle");

  chk_start_taken: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    (state_reg == urr_pkg::URR_IDLE && startReq && !echoSync_reg)
      |=> (state_reg == urr_pkg::URR_TRIG && trigOut))
    else $error("request not taken while idle");

  chk_echo_refused: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    (state_reg == urr_pkg::URR_IDLE && echoSync_reg) |=> !busy)
    else $error("measurement started with echo high");

  chk_trig_min_width: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    $rose(trigOut) |-> trigOut [*8])
    else $error("trigger pulse too short");

  chk_trig_exact_width: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    $fell(trigOut) |-> trigLen_reg == urr_pkg::CNT_W'(TRIG_CYCLES))
    else $error("trigger pulse width wrong");

  chk_trig_ends_wait: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    $fell(trigOut) |-> state_reg == urr_pkg::URR_WRISE)
    else $error("trigger did not lead to echo wait");

  chk_rise_starts: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    (state_reg == urr_pkg::URR_WRISE && echoRise) |=> (state_reg == urr_pkg::URR_WFALL
      && cnt_reg == '0))
    else $error("count not started at rising edge");

  chk_count_runs: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    (state_reg == urr_pkg::URR_WFALL && !echoFall
      && cnt_reg < urr_pkg::CNT_W'(TMO_CYCLES - 1)) |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("echo high time not counted");

  chk_fall_capture: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
    (state_reg == urr_pkg::URR_WFALL && echoFall) |=> (cap_reg == $past(cnt_reg)
      && state_reg == urr_pkg::URR_CALC))
    else $error("falling edge count not captured");

  chk_capture_stable: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
    !(state_reg == urr_pkg::URR_WFALL && echoFall) |=> $stable(cap_reg))
    else $error("captured count changed without falling edge");

  chk_calc_after_fall: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    (state_reg == urr_pkg::URR_CALC) |-> $past(state_reg) == urr_pkg::URR_WFALL)
    else $error("calculation without capture");

  chk_result_follows: assert property (@(posedge mclk) disable iff (!rst_n) // [R7]
    (state_reg == urr_pkg::URR_CALC) |=> resultValid && !busy)
    else $error("result not issued after capture");

  chk_wait_bounded: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    (state_reg == urr_pkg::URR_WRISE || state_reg == urr_pkg::URR_WFALL)
      |-> cnt_reg < urr_pkg::CNT_W'(TMO_CYCLES))
    else $error("echo wait ran past its timeout");

  chk_timeout_fires: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    (((state_reg == urr_pkg::URR_WRISE && !echoRise)
      || (state_reg == urr_pkg::URR_WFALL && !echoFall))
      && cnt_reg == urr_pkg::CNT_W'(TMO_CYCLES - 1)) |=> resultTimeout && !busy)
    else $error("timeout not reported");

  chk_timeout_idle: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    resultTimeout |-> (state_reg == urr_pkg::URR_IDLE && !resultValid))
    else $error("timeout with result or not idle");

  chk_no_both: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    resultValid |-> !resultTimeout && $past(state_reg) == urr_pkg::URR_CALC)
    else $error("result without calculation");
endmodule // urr_host

// file: urr_sensor_model.sv
// Purpose: behavioural ranging sensor for the host bench
// Assumes: width zero means the sensor never answers
// Notes:   echo driven push-pull, idle low
`timescale 1ns/10ps
module urr_sensor_model #(
  parameter int MIN_TRIG   = 10,
  // half period of the 40 kHz burst in mclk cycles
  parameter int BURST_HALF = 3125
) (
  input  wire logic        mclk,
  input  wire logic        trig,
  input  wire logic [15:0] delayCyc,
  input  wire logic [15:0] widthCyc,
  output logic             echo
);
  logic burstWave;
  int   hi;
  initial begin
    echo      = 1'b0;
    burstWave = 1'b0;
    hi        = 0;
    forever begin
      @(posedge mclk);
      if (trig) begin
        hi++;
      end else if (hi > 0) begin
        if (hi >= MIN_TRIG && widthCyc != 16'h0000) begin
          repeat (16) begin
            repeat (BURST_HALF) @(posedge mclk);
            burstWave <= ~burstWave;
          end
          repeat (delayCyc) @(posedge mclk);
          echo <= 1'b1;
          repeat (widthCyc) @(posedge mclk);
          echo <= 1'b0;
        end
        hi = 0;
      end
    end
  end
endmodule // urr_sensor_model

// file: ultrasonic_range_readout_tb_top.sv
// Purpose: self-checking bench for the range readout host
// Assumes: trigger 10 cycles, timeout 5000 cycles
// Notes:   echoCycles expected as echo high cycles minus one
`timescale 1ns/10ps
module ultrasonic_range_readout_tb_top;
  logic        mclk, rst_n, startReq, busy, trigOut, echo;
  logic        resultValid, resultTimeout;
  logic [23:0] echoCycles;
  logic [15:0] distanceMm, dly, wid;
  int          nFail, totalChecks, cyc, hiN;
  urr_host #(.TRIG_CYCLES(10), .TMO_CYCLES(5000)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .startReq(startReq), .busy(busy), .trigOut(trigOut), .echoIn(echo),
    .resultValid(resultValid), .resultTimeout(resultTimeout),
    .echoCycles(echoCycles), .distanceMm(distanceMm));
  urr_sensor_model #(.MIN_TRIG(10), .BURST_HALF(2)) u_sensor (.mclk(mclk), .trig(trigOut),
    .delayCyc(dly), .widthCyc(wid), .echo(echo));
  task automatic stopTest;
    if (nFail == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chkVal(input logic [23:0] got, input logic [23:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // reset held three edges, outputs checked idle once after the second
  task automatic reset_idle;
    repeat (2) @(posedge mclk);
    #1;
    chkVal(24'({trigOut, busy, resultValid, resultTimeout}), 24'h0);
    chkVal(echoCycles, 24'h0);
    chkVal(24'(distanceMm), 24'h0);
    @(posedge mclk) rst_n <= 1'b1;
  endtask
  // one request, counts trigger high time until a result or timeout pulse
  task automatic run(input logic [15:0] d, input logic [15:0] w, output logic tmo);
    dly <= d;
    wid <= w;
    @(posedge mclk) startReq <= 1'b1;
    @(posedge mclk) startReq <= 1'b0;
    hiN = 0;
    repeat (20000) begin
      #1;
      if (trigOut === 1'b1) hiN++;
      if (resultValid === 1'b1 || resultTimeout === 1'b1) break;
      @(posedge mclk);
    end
    tmo = resultTimeout;
    chkVal(24'(resultValid ^ resultTimeout), 24'h1);
  endtask
  task automatic measure(input logic [15:0] w);
    logic t;
    run(16'h0010, w, t);
    chkVal(24'(hiN), 24'hA);
    chkVal(24'(t), 24'h0);
    chkVal(echoCycles, 24'(w) - 24'h1);
    chkVal(24'(distanceMm), ((24'(w) - 24'h1) * 24'h11) / 24'h61A8);
  endtask
  task automatic no_echo;
    logic t;
    logic [23:0] old;
    old = echoCycles;
    run(16'h0004, 16'h0000, t);
    chkVal(24'(t), 24'h1);
    chkVal(echoCycles, old);
  endtask
  task automatic stuck_echo;
    logic t;
    run(16'h0004, 16'h1770, t);
    chkVal(24'(t), 24'h1);
    @(posedge mclk) startReq <= 1'b1;
    @(posedge mclk) startReq <= 1'b0;
    @(posedge mclk);
    #1;
    chkVal(24'({busy, trigOut}), 24'h0);
    wait (echo === 1'b0);
    repeat (4) @(posedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      nFail++;
      stopTest;
    end
  end
  initial begin
    rst_n       = 1'b0;
    startReq    = 1'b0;
    dly         = 16'h0010;
    wid         = 16'h0028;
    nFail       = 0;
    totalChecks = 0;
    reset_idle();
    measure(16'h0028);
    measure(16'h0BB8);
    no_echo();
    stuck_echo();
    measure(16'h0002);
    stopTest;
  end
endmodule // ultrasonic_range_readout_tb_top
